// ==== pcs_pkg.sv ====
// ============================================================
// Shared constants for the program flow and indirect block.
// ============================================================
package pcs_pkg;

   // ============================================================
   // Device variants.
   // ============================================================
   localparam int VAR_SMALL = 0;
   localparam int VAR_MID = 1;
   localparam int VAR_LARGE = 2;

   // Counter width of the small variant and of the mid and large variants.
   localparam int PC_W_SMALL = 9;
   localparam int PC_W_LARGE = 11;

   // ============================================================
   // Data sizes and file addresses.
   // ============================================================
   localparam int DATA_W = 8;
   localparam int FADDR_W = 5;
   localparam int IMM_W = 9;
   localparam int MEM_ADDR_W = 8;
   localparam logic [4:0] ADDR_INDIRECT = 5'h00;
   localparam logic [4:0] ADDR_PC_LOW = 5'h02;
   localparam logic [4:0] ADDR_STATUS = 5'h03;
   localparam logic [4:0] ADDR_POINTER = 5'h04;

   // ============================================================
   // Field positions.
   // ============================================================
   localparam int STAT_PAGE_LSB = 5;
   localparam int STAT_PAGE_MSB = 6;
   localparam int PAGE_W = 2;
   localparam int PTR_OFS_W = 5;
   localparam int PC_LOW_W = 8;
   localparam int PC_BIT8 = 8;

   // Pointer bits actually built for each variant.
   localparam logic [7:0] PTR_MASK_SMALL = 8'h1f;
   localparam logic [7:0] PTR_MASK_MID = 8'h7f;
   localparam logic [7:0] PTR_MASK_LARGE = 8'hff;

   // ============================================================
   // Reset values and the window self read value.
   // ============================================================
   localparam logic [1:0] PAGE_RST = 2'h0;
   localparam logic [7:0] PTR_RST = 8'h00;
   localparam logic [7:0] INDIRECT_SELF_READ = 8'h00;

   // Instruction class supplied by the decoder.
   typedef enum logic [1:0] {
      OP_SEQ,
      OP_JUMP,
      OP_CALL,
      OP_RETURN_WITH_LITERAL
   } pcs_op_t;

endpackage : pcs_pkg

// ==== pcs_return_stack.sv ====
// ============================================================
// Two-level return address stack.
// ============================================================
module pcs_return_stack #(
   parameter int WIDTH = 11
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic push,
   input wire logic pop,
   input wire logic [WIDTH-1:0] push_data,
   output logic [WIDTH-1:0] top_of_return_stack,
   output logic [WIDTH-1:0] level_two
);
   import pcs_pkg::*;

   logic [WIDTH-1:0] level_one;
   logic [WIDTH-1:0] next_level_one;
   logic [WIDTH-1:0] next_level_two;

   // A push shifts level one down and discards the old level two.
   // A pop copies level two up and leaves level two as it was.
   assign next_level_one = push ? push_data : (pop ? level_two : level_one);
   assign next_level_two = push ? level_one : level_two;

   // Both levels clear at reset.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         level_one <= '0;
         level_two <= '0;
      end else begin
         level_one <= next_level_one;
         level_two <= next_level_two;
      end
   end

   // Read data come straight from the level registers.
   assign top_of_return_stack = level_one;

endmodule : pcs_return_stack

// ==== pcs_flow.sv ====
module pcs_flow #(
   parameter int VARIANT = pcs_pkg::VAR_LARGE
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire pcs_pkg::pcs_op_t op_class,
   input wire logic [pcs_pkg::IMM_W-1:0] op_imm,
   input wire logic [pcs_pkg::FADDR_W-1:0] file_addr,
   input wire logic file_rd,
   input wire logic file_wr,
   input wire logic [pcs_pkg::DATA_W-1:0] file_wdata,
   output logic [pcs_pkg::DATA_W-1:0] file_rdata,
   output logic file_own,
   output logic [pcs_pkg::MEM_ADDR_W-1:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic [pcs_pkg::DATA_W-1:0] mem_wdata,
   input wire logic [pcs_pkg::DATA_W-1:0] mem_rdata,
   output logic work_load,
   output logic [pcs_pkg::DATA_W-1:0] work_data,
   output logic [10:0] prog_addr,
   output logic [pcs_pkg::PAGE_W-1:0] page_preselect
);
   import pcs_pkg::*;

   // ============================================================
   // Variant dependent sizes.
   // ============================================================

   // Counter and stack width follow the variant.
   localparam int PC_W = (VARIANT == VAR_SMALL) ? PC_W_SMALL : PC_W_LARGE;

   // Mask of the pointer bits that exist as flip-flops.
   localparam logic [7:0] PTR_MASK = (VARIANT == VAR_SMALL) ? PTR_MASK_SMALL :
                                     (VARIANT == VAR_MID) ? PTR_MASK_MID : PTR_MASK_LARGE;

   // True when the counter has page bits above bit 8.
   localparam bit HAS_PAGES = (VARIANT != VAR_SMALL);

   // ============================================================
   // Declarations.
   // ============================================================
   logic [PC_W-1:0] pc;
   logic [PC_W-1:0] next_pc;
   logic [PC_W-1:0] pc_plus_one;
   logic [PC_W-1:0] jump_target;
   logic [PC_W-1:0] call_target;
   logic [PC_W-1:0] stack_top;
   logic [PC_W-1:0] page_field;
   logic [PAGE_W-1:0] next_page_preselect;
   logic [DATA_W-1:0] pointer_q;
   logic [DATA_W-1:0] next_pointer;
   logic [DATA_W-1:0] indirect_pointer;
   logic [DATA_W-1:0] status_read;
   logic [DATA_W-1:0] pc_low_byte;
   logic [DATA_W-1:0] call_byte;
   logic [MEM_ADDR_W-1:0] indirect_addr;
   logic [MEM_ADDR_W-1:0] direct_addr;
   logic hit_indirect;
   logic hit_pc_low;
   logic hit_status;
   logic hit_pointer;
   logic window_on_self;
   logic pc_low_write;
   logic is_jump;
   logic is_call;
   logic is_return;
   logic push;
   logic pop;

   // ============================================================
   // Address decode of the file registers owned here.
   // ============================================================

   // Each owned file address is compared once.
   assign hit_indirect = (file_addr == ADDR_INDIRECT);
   assign hit_pc_low = (file_addr == ADDR_PC_LOW);
   assign hit_status = (file_addr == ADDR_STATUS);
   assign hit_pointer = (file_addr == ADDR_POINTER);

   // The data path merges our read data for the addresses we claim.
   assign file_own = hit_pc_low | hit_status | hit_pointer | hit_indirect;

   // Instruction class decode.
   assign is_jump = (op_class == OP_JUMP);
   assign is_call = (op_class == OP_CALL);
   assign is_return = (op_class == OP_RETURN_WITH_LITERAL);

   // A write to the low counter byte is a computed jump.
   assign pc_low_write = file_wr & hit_pc_low;

   // ============================================================
   // Program counter target values.
   // ============================================================

   // Sequential step; a carry out of bit 8 walks into the next page
   // without touching the page preselect bits.
   assign pc_plus_one = pc + PC_W'(1);

   // Page preselect bits placed at counter bits 10:9 on paged parts.
   generate
      if (HAS_PAGES) begin : g_page
         assign page_field = {page_preselect, {(PC_W-PAGE_W){1'b0}}};
      end else begin : g_nopage
         assign page_field = '0;
      end
   endgenerate

   // Jump target: immediate bits 8:0 plus the page field.
   assign jump_target = page_field | PC_W'(op_imm);

   // Call takes its byte from the instruction, a computed jump from
   // the result written to the low byte.
   assign call_byte = is_call ? op_imm[PC_LOW_W-1:0] : file_wdata;

   // Bit 8 stays zero so calls land in the first half of a page.
   assign call_target = page_field | PC_W'(call_byte);

   // ============================================================
   // Next counter value, in priority order.
   // ============================================================

   // Return beats call, call beats jump, jump beats a low byte write,
   // and with nothing loading it the counter steps by one.
   always_comb begin
      next_pc = pc_plus_one;
      if (is_return) begin
         next_pc = stack_top;
      end else if (is_call) begin
         next_pc = call_target;
      end else if (is_jump) begin
         next_pc = jump_target;
      end else if (pc_low_write) begin
         next_pc = call_target;
      end
   end

   // Counter register; reset lands on the last word of the last page.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pc <= '1;
      end else begin
         pc <= next_pc;
      end
   end

   // Fetch address, zero extended on the smallest variant.
   assign prog_addr = 11'(pc);

   // Low counter byte as seen by a file read.
   assign pc_low_byte = pc[PC_LOW_W-1:0];

   // ============================================================
   // Page preselect bits.
   // ============================================================

   // Software writes the page field through the status address only;
   // increments never change it.
   assign next_page_preselect = (file_wr & hit_status) ?
                                file_wdata[STAT_PAGE_MSB:STAT_PAGE_LSB] :
                                page_preselect;

   // Page zero is preselected after reset.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         page_preselect <= PAGE_RST;
      end else begin
         page_preselect <= next_page_preselect;
      end
   end

   // Status read shows only the page field; other bits read zero here.
   assign status_read = DATA_W'({page_preselect, {STAT_PAGE_LSB{1'b0}}});

   // ============================================================
   // Return stack.
   // ============================================================

   // Call pushes the address after the call; return pops.
   assign push = is_call;
   assign pop = is_return;

   pcs_return_stack #(
      .WIDTH(PC_W)
   ) u_stack (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .push(push),
      .pop(pop),
      .push_data(pc_plus_one),
      .top_of_return_stack(stack_top),
      .level_two()
   );

   // Return also hands its literal to the working register.
   assign work_load = is_return;
   assign work_data = op_imm[DATA_W-1:0];

   // ============================================================
   // Indirect pointer.
   // ============================================================

   // A write through the pointer address updates the built bits.
   assign next_pointer = (file_wr & hit_pointer) ? (file_wdata & PTR_MASK) : pointer_q;

   // Only the bits in the mask are real flip-flops; the others are
   // constant ones on read, so clearing never yields zero there.
   generate
      for (genvar b = 0; b < DATA_W; b++) begin : g_ptr
         if (PTR_MASK[b]) begin : g_built
            always_ff @(posedge sys_clk or negedge arst_n) begin
               if (!arst_n) begin
                  pointer_q[b] <= PTR_RST[b];
               end else begin
                  pointer_q[b] <= next_pointer[b];
               end
            end
            assign indirect_pointer[b] = pointer_q[b];
         end else begin : g_unbuilt
            assign pointer_q[b] = 1'b0;
            assign indirect_pointer[b] = 1'b1;
         end
      end
   endgenerate

   // ============================================================
   // Indirect data window.
   // ============================================================

   // Offset from bits 4:0, bank from the built bank bits above them.
   // The smallest variant has no bank bits, so its bank is zero.
   assign indirect_addr = (pointer_q & PTR_MASK);

   // Direct accesses reach bank zero at the file address.
   assign direct_addr = MEM_ADDR_W'(file_addr);

   // The pointer aiming at the window address reaches nothing.
   assign window_on_self = (pointer_q[PTR_OFS_W-1:0] == ADDR_INDIRECT);

   // Memory port: window accesses are redirected through the pointer.
   assign mem_addr = hit_indirect ? indirect_addr : direct_addr;
   assign mem_rd = file_rd & ~(hit_pc_low | hit_status | hit_pointer) &
                   ~(hit_indirect & window_on_self);
   assign mem_wr = file_wr & ~(hit_pc_low | hit_status | hit_pointer) &
                   ~(hit_indirect & window_on_self);
   assign mem_wdata = file_wdata;

   // ============================================================
   // File read data.
   // ============================================================

   // Owned registers answer from here; the window answers from memory
   // unless it points at itself, which reads as zero.
   always_comb begin
      file_rdata = mem_rdata;
      if (hit_pc_low) begin
         file_rdata = pc_low_byte;
      end else if (hit_status) begin
         file_rdata = status_read;
      end else if (hit_pointer) begin
         file_rdata = indirect_pointer;
      end else if (hit_indirect && window_on_self) begin
         file_rdata = INDIRECT_SELF_READ;
      end else if (hit_indirect) begin
         file_rdata = mem_rdata;
      end
   end

   // The core is expected to hold op_class, op_imm, file_* steady
   // through each instruction cycle; nothing here re-times them.

endmodule : pcs_flow

// ==== pcs_data_mem.sv ====
// ==========
// Data memory that sits beyond the indirect and direct file access.
// ==========
module pcs_data_mem (
   input wire logic sys_clk,
   input wire logic [7:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [256];
   logic [7:0] junk = 8'h5a;

   // Stores on the edge and scrambles the idle read lines every cycle.
   always @(posedge sys_clk) begin
      if (mem_wr) begin
         mem[mem_addr] <= mem_wdata;
      end
      junk <= ~junk;
   end

   // Unselected reads show a moving pattern, never the last value.
   assign mem_rdata = mem_rd ? mem[mem_addr] : junk;
endmodule : pcs_data_mem

// ==== pcs_flow_sva.sv ====
// ==========
// Port checker for the program flow and indirect block.
// ==========
module pcs_flow_sva #(
   parameter int VARIANT = pcs_pkg::VAR_LARGE
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire pcs_pkg::pcs_op_t op_class,
   input wire logic [8:0] op_imm,
   input wire logic [4:0] file_addr,
   input wire logic file_rd,
   input wire logic file_wr,
   input wire logic [7:0] file_wdata,
   input wire logic [7:0] file_rdata,
   input wire logic file_own,
   input wire logic [7:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   input wire logic work_load,
   input wire logic [7:0] work_data,
   input wire logic [10:0] prog_addr,
   input wire logic [1:0] page_preselect
);
   timeunit 1ns;
   timeprecision 100ps;
   import pcs_pkg::*;
   localparam logic [10:0] RST_PC = (VARIANT == VAR_SMALL) ? 11'h1ff : 11'h7ff;
   localparam logic [7:0] MASK = (VARIANT == VAR_SMALL) ? PTR_MASK_SMALL :
                                 (VARIANT == VAR_MID) ? PTR_MASK_MID : PTR_MASK_LARGE;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   // Effective page bits and the low byte write decode.
   wire logic [1:0] pg = (VARIANT == VAR_SMALL) ? 2'h0 : page_preselect;
   wire logic pcw = file_wr && file_addr == ADDR_PC_LOW;

   // Counter loading and stepping, return literal, page bits and indirect window.
   a_seq_step: assert property (op_class == OP_SEQ && !pcw |=> prog_addr == (($past(prog_addr) + 11'h1) & RST_PC))
      else $error("counter did not step by one");
   a_jump_load: assert property (op_class == OP_JUMP |=> prog_addr == {$past(pg), $past(op_imm)})
      else $error("jump target wrong");
   a_call_load: assert property (op_class == OP_CALL |=> prog_addr == {$past(pg), 1'b0, $past(op_imm[7:0])})
      else $error("call target wrong");
   a_low_write: assert property (op_class == OP_SEQ && pcw |=> prog_addr == {$past(pg), 1'b0, $past(file_wdata)})
      else $error("low byte write target wrong");
   a_call_return: assert property (op_class == OP_CALL ##1 op_class == OP_RETURN_WITH_LITERAL |=>
      prog_addr == (($past(prog_addr, 2) + 11'h1) & RST_PC))
      else $error("return address wrong");
   a_return_with_literal_work: assert property (op_class == OP_RETURN_WITH_LITERAL |-> work_load && work_data == op_imm[7:0])
      else $error("return literal not loaded");
   a_reset_vector: assert property ($rose(arst_n) |-> prog_addr == RST_PC && page_preselect == PAGE_RST)
      else $error("reset values wrong");
   a_page_hold: assert property (!(file_wr && file_addr == ADDR_STATUS) |=> $stable(page_preselect))
      else $error("page bits changed without write");
   a_page_write: assert property (file_wr && file_addr == ADDR_STATUS |=> page_preselect == $past(file_wdata[6:5]))
      else $error("page bits not written");
   a_self_guard: assert property (file_addr == ADDR_INDIRECT && mem_addr[4:0] == 5'h00 |->
      !mem_wr && !mem_rd && (!file_rd || file_rdata == INDIRECT_SELF_READ))
      else $error("window on itself reached memory");
   a_window_addr: assert property (file_wr && file_addr == ADDR_POINTER ##1 file_addr == ADDR_INDIRECT |->
      mem_addr == ($past(file_wdata) & MASK))
      else $error("window address wrong");
   a_window_data: assert property (file_rd && file_addr == ADDR_INDIRECT && mem_rd |-> file_rdata == mem_rdata)
      else $error("window read data wrong");

   // Main scenarios reached.
   c_call_ret: cover property (op_class == OP_CALL ##1 op_class == OP_RETURN_WITH_LITERAL);
   c_jump: cover property (op_class == OP_JUMP && page_preselect == 2'h3);
   c_bank: cover property (mem_rd && mem_addr[7:5] != 3'h0);
endmodule : pcs_flow_sva

bind pcs_flow pcs_flow_sva #(.VARIANT(VARIANT)) u_sva (
   .sys_clk(sys_clk), .arst_n(arst_n), .op_class(op_class), .op_imm(op_imm),
   .file_addr(file_addr), .file_rd(file_rd), .file_wr(file_wr), .file_wdata(file_wdata),
   .file_rdata(file_rdata), .file_own(file_own), .mem_addr(mem_addr), .mem_rd(mem_rd),
   .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .work_load(work_load),
   .work_data(work_data), .prog_addr(prog_addr), .page_preselect(page_preselect)
);

// ==== tb_pcs_flow.sv ====
// ==========
// Bench for the program flow and indirect block, largest variant.
// ==========
module tb_pcs_flow;
   timeunit 1ns;
   timeprecision 100ps;
   import pcs_pkg::*;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   pcs_op_t op_class = OP_SEQ;
   logic [8:0] op_imm = 9'h000;
   logic [4:0] file_addr = 5'h00;
   logic file_rd = 1'b0;
   logic file_wr = 1'b0;
   logic [7:0] file_wdata = 8'h00;
   logic [7:0] file_rdata, mem_addr, mem_wdata, mem_rdata, work_data;
   logic file_own, mem_rd, mem_wr, work_load;
   logic [10:0] prog_addr;
   logic [1:0] page_preselect;
   int fails = 0;
   int tests_run = 0;

   // Clock of 5 ns period.
   always #2.5 sys_clk = ~sys_clk;

   pcs_flow #(.VARIANT(VAR_LARGE)) dut (
      .sys_clk(sys_clk), .arst_n(arst_n), .op_class(op_class), .op_imm(op_imm),
      .file_addr(file_addr), .file_rd(file_rd), .file_wr(file_wr), .file_wdata(file_wdata),
      .file_rdata(file_rdata), .file_own(file_own), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .work_load(work_load),
      .work_data(work_data), .prog_addr(prog_addr), .page_preselect(page_preselect)
   );
   pcs_data_mem u_mem (.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   // Presents one instruction cycle; the previous one takes effect on this edge.
   task automatic cyc(input pcs_op_t op, input logic [8:0] imm, input logic [4:0] a,
                      input logic r, input logic w, input logic [7:0] d);
      @(posedge sys_clk);
      op_class <= op;
      op_imm <= imm;
      file_addr <= a;
      file_rd <= r;
      file_wr <= w;
      file_wdata <= d;
      #1;
   endtask : cyc

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      cyc(OP_SEQ, 9'h000, a, 1'b0, 1'b1, d);
   endtask : wr

   task automatic rd(input logic [4:0] a);
      cyc(OP_SEQ, 9'h000, a, 1'b1, 1'b0, 8'h00);
   endtask : rd

   task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out

   // Main sequence of tests.
   initial begin
      repeat (5) @(posedge sys_clk);
      arst_n <= 1'b1;
      #1;
      chk("pc reset", 11'h7ff, prog_addr);
      chk("page reset", 11'h000, {9'h000, page_preselect});
      rd(ADDR_POINTER);
      chk("pc wrap", 11'h000, prog_addr);
      chk("pointer reset", 11'h000, {3'h0, file_rdata});
      chk("own pointer", 11'h001, {10'h000, file_own});
      $display("test reset done");
      for (int p = 0; p < 4; p++) begin
         wr(ADDR_STATUS, {1'b0, p[1:0], 5'h00});
         cyc(OP_JUMP, 9'h1a5, 5'h00, 1'b0, 1'b0, 8'h00);
         rd(ADDR_PC_LOW);
         chk("jump target", {p[1:0], 9'h1a5}, prog_addr);
         chk("low byte", 11'h0a5, {3'h0, file_rdata});
      end
      $display("test jump done");
      cyc(OP_CALL, 9'h140, 5'h00, 1'b0, 1'b0, 8'h00);
      cyc(OP_CALL, 9'h080, 5'h00, 1'b0, 1'b0, 8'h00);
      chk("call target", 11'h640, prog_addr);
      cyc(OP_CALL, 9'h010, 5'h00, 1'b0, 1'b0, 8'h00);
      cyc(OP_RETURN_WITH_LITERAL, 9'h0a5, 5'h00, 1'b0, 1'b0, 8'h00);
      chk("call target", 11'h610, prog_addr);
      chk("literal", 11'h1a5, {2'h0, work_load, work_data});
      cyc(OP_RETURN_WITH_LITERAL, 9'h05a, 5'h00, 1'b0, 1'b0, 8'h00);
      chk("return one", 11'h681, prog_addr);
      cyc(OP_RETURN_WITH_LITERAL, 9'h03c, 5'h00, 1'b0, 1'b0, 8'h00);
      chk("return two", 11'h641, prog_addr);
      cyc(OP_SEQ, 9'h000, 5'h00, 1'b0, 1'b0, 8'h00);
      chk("return three", 11'h641, prog_addr);
      $display("test stack done");
      wr(ADDR_PC_LOW, 8'h33);
      wr(ADDR_POINTER, 8'h08);
      chk("low write", 11'h633, prog_addr);
      $display("test low byte done");
      wr(5'h08, 8'h10);
      chk("own plain", 11'h000, {10'h000, file_own});
      wr(5'h09, 8'h0a);
      wr(ADDR_POINTER, 8'he8);
      wr(ADDR_INDIRECT, 8'h77);
      rd(ADDR_INDIRECT);
      chk("bank seven", 11'h077, {3'h0, file_rdata});
      wr(ADDR_POINTER, 8'h09);
      rd(ADDR_INDIRECT);
      chk("window 09", 11'h00a, {3'h0, file_rdata});
      wr(ADDR_POINTER, 8'h08);
      rd(ADDR_INDIRECT);
      chk("window 08", 11'h010, {3'h0, file_rdata});
      wr(ADDR_POINTER, 8'h00);
      rd(ADDR_INDIRECT);
      chk("self read", 11'h000, {2'h0, mem_rd, file_rdata});
      wr(ADDR_INDIRECT, 8'h55);
      chk("self write", 11'h000, {10'h000, mem_wr});
      wr(ADDR_POINTER, 8'hff);
      rd(ADDR_POINTER);
      chk("pointer width", 11'h0ff, {3'h0, file_rdata});
      $display("test indirect done");
      close_out();
   end
endmodule : tb_pcs_flow
